// ===== verilog/esf_event_status.sv
// Event status flags, group summary, event signalling and watchdog reset request
//
// What this block does
// - A flag clears only when the host writes one to it; zeros do nothing.
// - Summary register is read-only, bits 7:4 reserved; bit 3 shows wake-pin events.
// - Summary bit 2 follows any pending transceiver event flag.
// - Summary bit 1 follows any pending supply event flag.
// - Summary bit 0 follows any pending system event flag.
// - Battery startup flag sets on leaving the off state after power-up.
// - Thermal warning flag sets above threshold, never in Sleep.
// - Serial failure flag sets when a frame is not 16, 24 or 32 clocks, outside Sleep.
// - Serial failure also on illegal codes or locked writes, outside Sleep.
// - Watchdog fault flag on overflow, or early trigger in Window mode.
// - Any Window-mode watchdog failure requests a system reset at once.
// - Timeout overflow resets only when the watchdog fault flag is already set.
// - Supply overvoltage sets bit 2, undervoltage sets bit 1.
// - Main regulator undervoltage sets bit 0 while active, not in Sleep.
// - Main undervoltage capture ignores the reset threshold selection.
// - Frame detection error sets transceiver bit 5.
// - Bus silence flag after timeout, armed only if enabled while active.
// - Battery startup, watchdog fault and frame error capture always enabled.
// - All other flags set only when their capture enable is set.
// - Receive output pulled low on pending events when offline with regulator on.
// - Transceiver bit 1 is bus fault, bit 0 bus wake-up while offline.
`timescale 1ns/1ps
`default_nettype none
module esf_event_status #(
  parameter int SILENCE_CYCLES = esf_pkg::SILENCE_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,

  // Register access from the serial interface decoder
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,

  // Operating state
  input wire logic sleep_mode,
  input wire logic main_regulator_active,
  input wire logic transceiver_offline,

  // Capture enables held elsewhere
  input wire logic thermal_warning_enable,
  input wire logic serial_failure_enable,
  input wire logic supply_over_enable,
  input wire logic supply_under_enable,
  input wire logic main_under_enable,
  input wire logic bus_silence_enable,
  input wire logic bus_fault_enable,
  input wire logic bus_wakeup_enable,

  // Wake-pin flags held elsewhere
  input wire logic [1:0] wake_pin_flags,

  // System events
  input wire logic off_state_exit,
  input wire logic thermal_over_warn,
  input wire logic frame_end,
  input wire logic [5:0] frame_bit_count,
  input wire logic illegal_code_write,
  input wire logic locked_reg_write,

  // Watchdog
  input wire logic wdg_window_mode,
  input wire logic wdg_timeout_mode,
  input wire logic wdg_overflow,
  input wire logic wdg_early_trigger,

  // Supply events
  input wire logic secondary_supply_over,
  input wire logic secondary_supply_under,
  input wire logic main_regulator_under,
  input wire logic [1:0] main_reset_threshold_sel,

  // Transceiver events
  input wire logic frame_detect_error,
  input wire logic bus_active,
  input wire logic bus_fault,
  input wire logic bus_wakeup,

  // Outputs
  output logic [7:0] global_event_summary,
  output logic event_rxd_n,
  output logic sys_reset_req
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic hit;
    logic rxd_n;
    logic reset_req;
    logic thermal_prev;
  } esf_state_s;

  esf_state_s state_ff;
  esf_state_s nxt_state;

  logic [7:0] sys_set;
  logic [7:0] sup_set;
  logic [7:0] trx_set;

  logic [7:0] sys_clr;
  logic [7:0] sup_clr;
  logic [7:0] trx_clr;

  logic [7:0] system_event_flags;
  logic [7:0] supply_event_flags;
  logic [7:0] transceiver_event_flags;

  logic silence_event;
  logic [7:0] summary;
  logic any_pending;
  logic wdg_fault_event;

  initial begin
    if (SILENCE_CYCLES < 1) begin
      $error("esf_event_status needs a silence timeout of at least one cycle");
    end
  end

  // ------------------------------------------------------------------
  // Event capture
  // ------------------------------------------------------------------
  // The threshold selection is kept as a port so that its independence is visible
  logic unused_threshold;
  assign unused_threshold = ^main_reset_threshold_sel;

  always_comb begin
    sys_set = 8'h00;
    sup_set = 8'h00;
    trx_set = 8'h00;

    sys_set[esf_pkg::SYS_BATTERY_STARTUP_BIT] = off_state_exit;

    // rising edge of the warning level, not in Sleep; gated by enable
    sys_set[esf_pkg::SYS_THERMAL_WARNING_BIT] = thermal_over_warn && !state_ff.thermal_prev &&
                                                !sleep_mode && thermal_warning_enable;

    // bad frame length, illegal codes or locked writes, all outside Sleep; enable
    sys_set[esf_pkg::SYS_SERIAL_FAILURE_BIT] = serial_failure_enable && !sleep_mode &&
        ((frame_end && !esf_pkg::esf_legal_frame(frame_bit_count)) ||
         illegal_code_write || locked_reg_write);

    sys_set[esf_pkg::SYS_WATCHDOG_FAULT_BIT] = wdg_fault_event;

    // secondary or external supply events; enables
    sup_set[esf_pkg::SUP_OVER_BIT] = secondary_supply_over && supply_over_enable;
    sup_set[esf_pkg::SUP_UNDER_BIT] = secondary_supply_under && supply_under_enable;

    // main undervoltage while active, not in Sleep; threshold select unused
    sup_set[esf_pkg::SUP_MAIN_UNDER_BIT] = main_regulator_under && main_regulator_active &&
                                           !sleep_mode && main_under_enable;

    trx_set[esf_pkg::TRX_FRAME_DETECT_ERROR_BIT] = frame_detect_error;

    trx_set[esf_pkg::TRX_BUS_SILENCE_BIT] = silence_event;

    // bus fault in any state, wake-up only while offline; enables
    trx_set[esf_pkg::TRX_BUS_FAULT_BIT] = bus_fault && bus_fault_enable;
    trx_set[esf_pkg::TRX_BUS_WAKEUP_BIT] = bus_wakeup && transceiver_offline &&
                                           bus_wakeup_enable;
  end

  // overflow in either mode, early trigger only in Window mode
  assign wdg_fault_event = (wdg_overflow && (wdg_window_mode || wdg_timeout_mode)) ||
                           (wdg_early_trigger && wdg_window_mode);

  // ------------------------------------------------------------------
  // Host clears
  // ------------------------------------------------------------------
  always_comb begin
    sys_clr = 8'h00;
    sup_clr = 8'h00;
    trx_clr = 8'h00;
    if (reg_wr) begin
      // ones clear; reserved bits and the summary ignore writes
      case (reg_addr)
        esf_pkg::SYSTEM_EVENT_FLAGS_OFS: begin
          sys_clr = reg_wdata & esf_pkg::SYS_IMPL_MASK;
        end
        esf_pkg::SUPPLY_EVENT_FLAGS_OFS: begin
          sup_clr = reg_wdata & esf_pkg::SUP_IMPL_MASK;
        end
        esf_pkg::TRANSCEIVER_EVENT_FLAGS_OFS: begin
          trx_clr = reg_wdata & esf_pkg::TRX_IMPL_MASK;
        end
        default: begin
          sys_clr = 8'h00;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Flag registers
  // ------------------------------------------------------------------
  esf_flag_reg #(
    .WIDTH(8),
    .IMPL_MASK(esf_pkg::SYS_IMPL_MASK)
  ) u_sys_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_vec(sys_set),
    .clr_vec(sys_clr),
    .flags(system_event_flags)
  );

  esf_flag_reg #(
    .WIDTH(8),
    .IMPL_MASK(esf_pkg::SUP_IMPL_MASK)
  ) u_sup_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_vec(sup_set),
    .clr_vec(sup_clr),
    .flags(supply_event_flags)
  );

  esf_flag_reg #(
    .WIDTH(8),
    .IMPL_MASK(esf_pkg::TRX_IMPL_MASK)
  ) u_trx_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_vec(trx_set),
    .clr_vec(trx_clr),
    .flags(transceiver_event_flags)
  );

  esf_silence_timer #(
    .TIMEOUT_CYCLES(SILENCE_CYCLES)
  ) u_silence (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_active(bus_active),
    .bus_silence_enable(bus_silence_enable),
    .silence_event(silence_event)
  );

  // ------------------------------------------------------------------
  // Group summary
  // ------------------------------------------------------------------
  always_comb begin
    summary = 8'h00;

    summary[esf_pkg::SUM_WAKE_PIN_BIT] = |wake_pin_flags;

    summary[esf_pkg::SUM_TRANSCEIVER_BIT] =
        esf_pkg::esf_any_pending(transceiver_event_flags, esf_pkg::TRX_IMPL_MASK);

    summary[esf_pkg::SUM_SUPPLY_BIT] =
        esf_pkg::esf_any_pending(supply_event_flags, esf_pkg::SUP_IMPL_MASK);

    summary[esf_pkg::SUM_SYSTEM_BIT] =
        esf_pkg::esf_any_pending(system_event_flags, esf_pkg::SYS_IMPL_MASK);
  end

  assign any_pending = |summary;

  // ------------------------------------------------------------------
  // Read path, signalling and reset request
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.thermal_prev = thermal_over_warn;
    nxt_state.hit = 1'b0;
    if (reg_rd) begin
      nxt_state.hit = 1'b1;
      // reserved bits read zero through the masks
      case (reg_addr)
        esf_pkg::GLOBAL_EVENT_SUMMARY_OFS: begin
          nxt_state.rdata = summary;
        end
        esf_pkg::SYSTEM_EVENT_FLAGS_OFS: begin
          nxt_state.rdata = system_event_flags & esf_pkg::SYS_IMPL_MASK;
        end
        esf_pkg::SUPPLY_EVENT_FLAGS_OFS: begin
          nxt_state.rdata = supply_event_flags & esf_pkg::SUP_IMPL_MASK;
        end
        esf_pkg::TRANSCEIVER_EVENT_FLAGS_OFS: begin
          nxt_state.rdata = transceiver_event_flags & esf_pkg::TRX_IMPL_MASK;
        end
        default: begin
          // Other addresses belong to neighbouring blocks
          nxt_state.rdata = esf_pkg::RDATA_RESET;
          nxt_state.hit = 1'b0;
        end
      endcase
    end

    // pull receive output low only when offline with the regulator on
    nxt_state.rxd_n = !(any_pending && transceiver_offline && main_regulator_active);
    nxt_state.reset_req = 1'b0;

    if (wdg_window_mode && wdg_fault_event) begin
      nxt_state.reset_req = 1'b1;
    end

    // Timeout overflow resets only with a fault already pending
    if (wdg_timeout_mode && wdg_overflow &&
        system_event_flags[esf_pkg::SYS_WATCHDOG_FAULT_BIT]) begin
      nxt_state.reset_req = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff.rdata <= esf_pkg::RDATA_RESET;
      state_ff.hit <= 1'b0;
      state_ff.rxd_n <= 1'b1;
      state_ff.reset_req <= 1'b0;
      state_ff.thermal_prev <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign reg_hit = state_ff.hit;
  assign event_rxd_n = state_ff.rxd_n;
  assign sys_reset_req = state_ff.reset_req;
  assign global_event_summary = summary;

endmodule : esf_event_status
`default_nettype wire

// ===== inc/esf_pkg.sv
// Shared constants, types and helpers of the event status flag block
package esf_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [6:0] GLOBAL_EVENT_SUMMARY_OFS = 7'h60;
  localparam logic [6:0] SYSTEM_EVENT_FLAGS_OFS = 7'h61;
  localparam logic [6:0] SUPPLY_EVENT_FLAGS_OFS = 7'h62;
  localparam logic [6:0] TRANSCEIVER_EVENT_FLAGS_OFS = 7'h63;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SUM_WAKE_PIN_BIT = 3;
  localparam int SUM_TRANSCEIVER_BIT = 2;
  localparam int SUM_SUPPLY_BIT = 1;
  localparam int SUM_SYSTEM_BIT = 0;

  localparam int SYS_BATTERY_STARTUP_BIT = 4;
  localparam int SYS_THERMAL_WARNING_BIT = 2;
  localparam int SYS_SERIAL_FAILURE_BIT = 1;
  localparam int SYS_WATCHDOG_FAULT_BIT = 0;

  localparam int SUP_OVER_BIT = 2;
  localparam int SUP_UNDER_BIT = 1;
  localparam int SUP_MAIN_UNDER_BIT = 0;

  localparam int TRX_FRAME_DETECT_ERROR_BIT = 5;
  localparam int TRX_BUS_SILENCE_BIT = 4;
  localparam int TRX_BUS_FAULT_BIT = 1;
  localparam int TRX_BUS_WAKEUP_BIT = 0;

  // Implemented bits; all others are reserved and read as zero
  localparam logic [7:0] SYS_IMPL_MASK = 8'h17;
  localparam logic [7:0] SUP_IMPL_MASK = 8'h07;
  localparam logic [7:0] TRX_IMPL_MASK = 8'h33;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ------------------------------------------------------------------
  // Serial frame lengths and timing
  // ------------------------------------------------------------------
  localparam logic [5:0] FRAME_LEN_16 = 6'h10;
  localparam logic [5:0] FRAME_LEN_24 = 6'h18;
  localparam logic [5:0] FRAME_LEN_32 = 6'h20;

  localparam int CLK_RATE_MHZ = 40;
  localparam int SILENCE_TIMEOUT_US = 1000;
  localparam int SILENCE_TIMEOUT_CYCLES = SILENCE_TIMEOUT_US * CLK_RATE_MHZ;

  // ------------------------------------------------------------------
  // Silence detector states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ESF_SIL_IDLE = 2'b00,
    ESF_SIL_ARMED = 2'b01,
    ESF_SIL_FIRED = 2'b11
  } esf_sil_state_e;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic esf_any_pending(input logic [7:0] flags, input logic [7:0] mask);
    esf_any_pending = |(flags & mask);
  endfunction : esf_any_pending

  function automatic logic esf_legal_frame(input logic [5:0] bit_count);
    esf_legal_frame = (bit_count == FRAME_LEN_16) || (bit_count == FRAME_LEN_24) ||
                      (bit_count == FRAME_LEN_32);
  endfunction : esf_legal_frame

endpackage : esf_pkg

// ===== verilog/esf_flag_reg.sv
// Write-one-to-clear flag register with set priority
`timescale 1ns/1ps
`default_nettype none
module esf_flag_reg #(
  parameter int WIDTH = 8,
  parameter logic [7:0] IMPL_MASK = 8'hff
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Hardware set and host clear
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clr_vec,
  // Flags
  output logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } esf_flag_state_s;

  esf_flag_state_s state_ff;
  esf_flag_state_s nxt_state;

  initial begin
    if (WIDTH != 8) begin
      $error("esf_flag_reg serves only 8-bit registers");
    end
  end

  always_comb begin
    nxt_state = state_ff;
    // set beats clear; only written ones clear
    nxt_state.flags = ((state_ff.flags & ~clr_vec) | set_vec) & IMPL_MASK[WIDTH-1:0];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff.flags <= esf_pkg::FLAGS_RESET[WIDTH-1:0];
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flags = state_ff.flags;

endmodule : esf_flag_reg
`default_nettype wire

// ===== verilog/esf_silence_timer.sv
// Bus silence detector: fires once after a quiet period that began while armed
`timescale 1ns/1ps
`default_nettype none
module esf_silence_timer #(
  parameter int TIMEOUT_CYCLES = esf_pkg::SILENCE_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus view
  input wire logic bus_active,
  input wire logic bus_silence_enable,
  // Event
  output logic silence_event
);

  typedef struct packed {
    esf_pkg::esf_sil_state_e st;
    logic [31:0] cnt;
    logic fire;
  } esf_sil_s;

  esf_sil_s state_ff;
  esf_sil_s nxt_state;

  initial begin
    if (TIMEOUT_CYCLES < 1) begin
      $error("esf_silence_timer needs a timeout of at least one cycle");
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.fire = 1'b0;
    case (state_ff.st)
      esf_pkg::ESF_SIL_IDLE: begin
        // arm only when enabled while the bus is active
        if (bus_silence_enable && bus_active) begin
          nxt_state.st = esf_pkg::ESF_SIL_ARMED;
          nxt_state.cnt = 32'h0000_0000;
        end
      end
      esf_pkg::ESF_SIL_ARMED: begin
        if (!bus_silence_enable) begin
          nxt_state.st = esf_pkg::ESF_SIL_IDLE;
        end else if (bus_active) begin
          nxt_state.cnt = 32'h0000_0000;
        end else if (state_ff.cnt == 32'(TIMEOUT_CYCLES - 1)) begin
          nxt_state.fire = 1'b1;
          nxt_state.st = esf_pkg::ESF_SIL_FIRED;
        end else begin
          nxt_state.cnt = state_ff.cnt + 32'h0000_0001;
        end
      end
      esf_pkg::ESF_SIL_FIRED: begin
        // One event per silence; wait for traffic before rearming
        if (bus_active || !bus_silence_enable) begin
          nxt_state.st = esf_pkg::ESF_SIL_IDLE;
        end
      end
      default: begin
        nxt_state.st = esf_pkg::ESF_SIL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff.st <= esf_pkg::ESF_SIL_IDLE;
      state_ff.cnt <= 32'h0000_0000;
      state_ff.fire <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign silence_event = state_ff.fire;

endmodule : esf_silence_timer
`default_nettype wire

// ===== verification/esf_event_status_assertions.sv
// Concurrent checks on the event status flag block ports
`timescale 1ns/1ps
`default_nettype none
module esf_event_status_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  // Conditions and events
  input wire logic transceiver_offline,
  input wire logic main_regulator_active,
  input wire logic bus_fault,
  input wire logic bus_fault_enable,
  input wire logic [1:0] wake_pin_flags,
  input wire logic wdg_window_mode,
  input wire logic wdg_timeout_mode,
  input wire logic wdg_overflow,
  input wire logic wdg_early_trigger,
  // Outputs
  input wire logic [7:0] global_event_summary,
  input wire logic event_rxd_n,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_SUM_RSVD: assert property (global_event_summary[7:4] == 4'h0)
    else $error("summary reserved bits set");
  AST_SUM_WAKE: assert property (global_event_summary[3] == |wake_pin_flags)
    else $error("summary wake bit wrong");
  AST_RD_SUM: assert property (reg_rd && reg_addr == 7'h60 |=>
    reg_hit && reg_rdata == $past(global_event_summary)) else $error("summary read wrong");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > 7'h63 |=>
    !reg_hit && reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_WIN_RST: assert property (wdg_window_mode && (wdg_overflow || wdg_early_trigger)
    |=> sys_reset_req) else $error("window failure gave no reset");
  AST_RST_CAUSE: assert property ($rose(sys_reset_req)
    |-> $past(wdg_overflow || wdg_early_trigger)) else $error("reset without cause");
  AST_WDF_SET: assert property ((wdg_overflow && (wdg_window_mode || wdg_timeout_mode))
    || (wdg_early_trigger && wdg_window_mode) |=> global_event_summary[0])
    else $error("watchdog fault not captured");
  AST_FAULT_SET: assert property (bus_fault && bus_fault_enable
    |=> global_event_summary[2]) else $error("bus fault not captured");
  AST_RXD_LOW: assert property ((|global_event_summary[2:0]) && transceiver_offline
    && main_regulator_active |=> !event_rxd_n) else $error("receive line not low");
  AST_RXD_HIGH: assert property (global_event_summary == 8'h00 |=> event_rxd_n)
    else $error("receive line low with nothing pending");
  AST_SYS_CLR: assert property ($fell(global_event_summary[0])
    |-> $past(reg_wr && reg_addr == 7'h61)) else $error("system flag cleared unasked");

  COV_WIN_RST: cover property (wdg_window_mode && wdg_early_trigger ##1 sys_reset_req);
  COV_FAULT: cover property (bus_fault && bus_fault_enable && reg_wr);
  COV_RD_SUM: cover property (reg_rd && reg_addr == 7'h60 ##1 reg_rdata != 8'h00);
endmodule : esf_event_status_assertions
`default_nettype wire

// ===== verification/esf_host_model.sv
// Host model that drives the register strobe port
`timescale 1ns/1ps
`default_nettype none
module esf_host_model (
  // Clock
  input wire logic sys_clk,
  // Register strobe port
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit
);
  initial begin
    reg_addr = 7'h7f;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Lines not worth a value once the strobe is gone
  task automatic idle();
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle
  // ones only where clearing is meant
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    idle();
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic h);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    h = reg_hit;
    idle();
  endtask : rd
endmodule : esf_host_model
`default_nettype wire

// ===== verification/event_status_flags_test.sv
// Self-checking bench for the event status flag block
`timescale 1ns/1ps
`default_nettype none
module event_status_flags_test;
  logic sys_clk, rst_n, reg_wr, reg_rd, reg_hit, bus_active, rxd_n, rst_req;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, en, summ;
  logic [4:0] md;
  logic [12:0] ev;
  logic [5:0] cnt;
  logic [1:0] sel, wake;
  int err_count = 0;
  int num_checks = 0;

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  esf_host_model i_host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_hit);

  // md is {timeout, window, offline, regulator on, sleep}
  esf_event_status #(.SILENCE_CYCLES(8)) i_dut (.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_hit, .sleep_mode(md[0]),
    .main_regulator_active(md[1]), .transceiver_offline(md[2]),
    .thermal_warning_enable(en[0]), .serial_failure_enable(en[1]),
    .supply_over_enable(en[2]), .supply_under_enable(en[3]), .main_under_enable(en[4]),
    .bus_silence_enable(en[5]), .bus_fault_enable(en[6]), .bus_wakeup_enable(en[7]),
    .wake_pin_flags(wake), .off_state_exit(ev[0]), .thermal_over_warn(ev[1]),
    .frame_end(ev[2]), .frame_bit_count(cnt), .illegal_code_write(ev[3]),
    .locked_reg_write(ev[4]), .wdg_window_mode(md[3]), .wdg_timeout_mode(md[4]),
    .wdg_overflow(ev[5]), .wdg_early_trigger(ev[6]), .secondary_supply_over(ev[7]),
    .secondary_supply_under(ev[8]), .main_regulator_under(ev[9]),
    .main_reset_threshold_sel(sel), .frame_detect_error(ev[10]), .bus_active,
    .bus_fault(ev[11]), .bus_wakeup(ev[12]), .global_event_summary(summ),
    .event_rxd_n(rxd_n), .sys_reset_req(rst_req));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic fire(input logic [12:0] v);
    @(negedge sys_clk);
    ev = v;
    @(negedge sys_clk);
    ev = 13'h0;
  endtask : fire

  task automatic ev_case(input logic [12:0] v, input logic [7:0] e, input logic [4:0] m,
                         input logic [6:0] a, input logic [7:0] x);
    logic [7:0] d;
    logic h;
    en = e;
    md = m;
    fire(v);
    i_host.rd(a, d, h);
    chk(d, x, "flag capture");
    i_host.rd(7'h60, d, h);
    chk(d, (x != 8'h00) ? (8'h01 << (a - 7'h61)) : 8'h00, "summary");
    i_host.wr(a, 8'hff);
    i_host.rd(a, d, h);
    chk(d, 8'h00, "flag clear");
  endtask : ev_case

  task automatic give_verdict();
    $display("Checks made: %0d, mismatches: %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Whole run needs about 315 cycles
  initial begin
    #100us;
    err_count++;
    $display("CHECK FAILED at %0t: run hung", $time);
    give_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin : main
    logic [7:0] d;
    logic h;
    rst_n = 1'b0;
    md = 5'h02;
    en = 8'h00;
    wake = 2'h1;
    ev = 13'h0;
    cnt = 6'h11;
    sel = 2'h0;
    bus_active = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_host.rd(7'h60 + 7'(i), d, h);
      chk(d, (i == 0) ? 8'h08 : 8'h00, "reset value");
      chk({7'h0, h}, 8'h01, "read hit");
    end
    wake = 2'h0;
    i_host.wr(7'h60, 8'hff);
    i_host.rd(7'h60, d, h);
    chk(d, 8'h00, "summary write");
    i_host.rd(7'h64, d, h);
    chk(d, 8'h00, "unmapped read");
    chk({7'h0, h}, 8'h00, "unmapped hit");
    ev_case(13'h0001, 8'h00, 5'h02, 7'h61, 8'h10);
    ev_case(13'h0002, 8'h01, 5'h02, 7'h61, 8'h04);
    ev_case(13'h0002, 8'h01, 5'h03, 7'h61, 8'h00);
    ev_case(13'h0002, 8'h00, 5'h02, 7'h61, 8'h00);
    ev_case(13'h0004, 8'h02, 5'h02, 7'h61, 8'h02);
    ev_case(13'h0008, 8'h02, 5'h02, 7'h61, 8'h02);
    ev_case(13'h0010, 8'h02, 5'h02, 7'h61, 8'h02);
    ev_case(13'h0010, 8'h02, 5'h03, 7'h61, 8'h00);
    ev_case(13'h0080, 8'h04, 5'h02, 7'h62, 8'h04);
    ev_case(13'h0100, 8'h08, 5'h02, 7'h62, 8'h02);
    ev_case(13'h0200, 8'h10, 5'h03, 7'h62, 8'h00);
    ev_case(13'h0400, 8'h00, 5'h02, 7'h63, 8'h20);
    ev_case(13'h0800, 8'h40, 5'h02, 7'h63, 8'h02);
    ev_case(13'h0800, 8'h00, 5'h02, 7'h63, 8'h00);
    ev_case(13'h1000, 8'h80, 5'h06, 7'h63, 8'h01);
    for (int i = 0; i < 4; i++) begin
      sel = 2'(i);
      ev_case(13'h0200, 8'h10, 5'h02, 7'h62, 8'h01);
    end
    for (int i = 0; i < 3; i++) begin
      cnt = (i == 0) ? 6'h10 : (i == 1) ? 6'h18 : 6'h20;
      ev_case(13'h0004, 8'h02, 5'h02, 7'h61, 8'h00);
    end
    en = 8'h01;
    fire(13'h0003);
    i_host.wr(7'h61, 8'h00);
    i_host.rd(7'h61, d, h);
    chk(d, 8'h14, "zero write");
    i_host.wr(7'h61, 8'h04);
    i_host.rd(7'h61, d, h);
    chk(d, 8'h10, "partial clear");
    i_host.wr(7'h61, 8'h10);
    en = 8'h40;
    md = 5'h06;
    fork
      i_host.wr(7'h63, 8'h02);
      fire(13'h0800);
    join
    i_host.rd(7'h63, d, h);
    chk(d, 8'h02, "set over clear");
    chk({7'h0, rxd_n}, 8'h00, "receive line low");
    i_host.wr(7'h63, 8'hff);
    @(negedge sys_clk);
    chk({7'h0, rxd_n}, 8'h01, "receive line released");
    md = 5'h12;
    fire(13'h0020);
    chk({7'h0, rst_req}, 8'h00, "first overflow");
    fire(13'h0020);
    chk({7'h0, rst_req}, 8'h01, "second overflow");
    i_host.wr(7'h61, 8'hff);
    md = 5'h0a;
    for (int i = 0; i < 2; i++) begin
      fire((i == 0) ? 13'h0020 : 13'h0040);
      chk({7'h0, rst_req}, 8'h01, "window failure");
      i_host.rd(7'h61, d, h);
      chk(d, 8'h01, "watchdog fault");
      i_host.wr(7'h61, 8'hff);
    end
    md = 5'h02;
    for (int i = 0; i < 2; i++) begin
      en = (i == 1) ? 8'h20 : 8'h00;
      @(negedge sys_clk);
      bus_active = 1'b1;
      repeat (2) @(negedge sys_clk);
      bus_active = 1'b0;
      repeat (14) @(negedge sys_clk);
      i_host.rd(7'h63, d, h);
      chk(d, (i == 1) ? 8'h10 : 8'h00, "bus silence");
      i_host.wr(7'h63, 8'hff);
    end
    give_verdict();
  end
endmodule : event_status_flags_test

bind esf_event_status esf_event_status_assertions i_chk (.sys_clk, .rst_n, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .reg_hit, .transceiver_offline, .main_regulator_active, .bus_fault,
  .bus_fault_enable, .wake_pin_flags, .wdg_window_mode, .wdg_timeout_mode, .wdg_overflow,
  .wdg_early_trigger, .global_event_summary, .event_rxd_n, .sys_reset_req);
`default_nettype wire
